/* src/fgt_pkg.sv */
// Constants, types and lookup functions for the fuel gauge tuning block.
// Assumes a 125 MHz clock and an AXI4-Lite register port with 12-bit address.
package fgt_pkg;

    // Clock and timebase
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned MS_PERIOD_NS = 1000000;
    localparam int unsigned MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned MS_PER_SEC = 1000;

    // Register indices (byte address is four times the index)
    localparam logic [9:0] IDX_INTERVAL_WAIT = 10'h0E9;
    localparam logic [9:0] IDX_DEBOUNCE_CAL = 10'h0EA;
    localparam logic [9:0] IDX_DISPLAY_DEC = 10'h0EB;
    localparam logic [9:0] IDX_STATUS = 10'h0F0;
    localparam logic [7:0] RST_INTERVAL_WAIT = 8'h00;
    localparam logic [7:0] RST_DEBOUNCE_CAL = 8'h00;
    localparam logic [7:0] RST_DISPLAY_DEC = 8'h00;
    localparam logic [6:0] RST_DISP_PCT = 7'h64;

    // Field positions
    localparam int unsigned F_INTV_LSB = 6;
    localparam int unsigned F_CHG_WAIT_LSB = 3;
    localparam int unsigned F_DIS_WAIT_LSB = 0;
    localparam int unsigned F_OCV_DEB_LSB = 6;
    localparam int unsigned F_CC_DEB_LSB = 4;
    localparam int unsigned F_START_BIT = 3;
    localparam int unsigned F_END0_BIT = 2;
    localparam int unsigned F_END1_BIT = 1;
    localparam int unsigned F_END2_BIT = 0;
    localparam int unsigned F_HOLD_BIT = 7;
    localparam int unsigned F_HYST_LSB = 4;

    // Calibration thresholds
    localparam logic [6:0] START_MARGIN_LO = 7'h03;
    localparam logic [6:0] START_MARGIN_HI = 7'h06;
    localparam logic [6:0] END_PCT_LO = 7'h5F;
    localparam logic [6:0] END_PCT_HI = 7'h64;
    localparam logic [6:0] FIN_WAIT_MS_LO = 7'h44;
    localparam logic [6:0] FIN_WAIT_MS_HI = 7'h78;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        FGT_CAL_IDLE = 2'h0,
        FGT_CAL_RUN = 2'h1,
        FGT_CAL_WAIT = 2'h3,
        FGT_CAL_DONE = 2'h2
    } fgt_cal_t;

    // Debounced percentage with its run of same-direction moves
    typedef struct packed {
        logic [6:0] pct;
        logic [1:0] dir;
        logic [3:0] cnt;
    } fgt_deb_t;

    // Correction interval in seconds
    function automatic logic [9:0] fgt_interval_s(input logic [1:0] code);
        case (code)
            2'h0: fgt_interval_s = 10'h03C;
            2'h1: fgt_interval_s = 10'h078;
            2'h2: fgt_interval_s = 10'h00F;
            default: fgt_interval_s = 10'h01E;
        endcase
    endfunction

    // Settling wait in seconds
    function automatic logic [9:0] fgt_settle_s(input logic [2:0] code);
        case (code)
            3'h0: fgt_settle_s = 10'h0B4;
            3'h1: fgt_settle_s = 10'h0F0;
            3'h2: fgt_settle_s = 10'h12C;
            3'h3: fgt_settle_s = 10'h258;
            3'h4: fgt_settle_s = 10'h01E;
            3'h5: fgt_settle_s = 10'h03C;
            3'h6: fgt_settle_s = 10'h05A;
            default: fgt_settle_s = 10'h078;
        endcase
    endfunction

    // Debounce move count
    function automatic logic [3:0] fgt_deb_n(input logic [1:0] code);
        case (code)
            2'h0: fgt_deb_n = 4'h4;
            2'h1: fgt_deb_n = 4'h8;
            2'h2: fgt_deb_n = 4'h1;
            default: fgt_deb_n = 4'h2;
        endcase
    endfunction

    // Decrease hysteresis in percent: codes 0-3 give 4-7, 4-7 give 0-3
    function automatic logic [6:0] fgt_hyst_pct(input logic [2:0] code);
        fgt_hyst_pct = {4'h0, code ^ 3'h4};
    endfunction

    // Register index from a byte address
    function automatic logic [9:0] fgt_index(input logic [11:0] addr);
        fgt_index = addr[11:2];
    endfunction

endpackage

/* src/fgt_tuning_regs.sv */
// Fuel gauge tuning registers and the timing, debounce, calibration and
// display-decrease logic they steer.
// Assumes one 125 MHz clock, AXI4-Lite master, synchronous gauge inputs.
//
// Function
// - Two-bit code picks correction interval 60, 120, 15 or 30 s.
// - Charge settling wait from three-bit code, 180 s to 120 s table.
// - Discharge settling wait has own three-bit code, same table.
// - Voltage percentage changes after more than N same-direction moves.
// - Charge-count percentage debounced alike with its own N code.
// - Calibration starts below threshold plus 3, or plus 6 when bit set.
// - First end condition: percentage at least 95, or exactly 100.
// - Second end bit chooses waiting for charge-finished or not.
// - After charging clears, wait 68 or 120 ms for charge-finished.
// - While charging, control bit allows or holds display decrease.
// - While charging, display drops only by a step of at least 0 to 7 percent.
// - Display decrease register resets to all zeros.
`timescale 1ns/100ps
`default_nettype none
module fgt_tuning_regs
    import fgt_pkg::*;
#(
    parameter int unsigned MS_CYC = fgt_pkg::MS_CYCLES,
    parameter int unsigned MS_SEC = fgt_pkg::MS_PER_SEC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Gauge inputs
    input wire logic [3:0] low_warning_threshold,
    input wire logic charging_status_bit,
    input wire logic charge_finished,
    input wire logic cal_enable,
    input wire logic rdc_charge_est,
    input wire logic rdc_discharge_est,
    input wire logic ocv_sample_valid,
    input wire logic [6:0] ocv_pct_raw,
    input wire logic cc_sample_valid,
    input wire logic [6:0] cc_pct_raw,
    input wire logic disp_req_valid,
    input wire logic [6:0] disp_req_pct,
    // Gauge outputs
    output logic correct_pulse,
    output logic chg_settled,
    output logic dis_settled,
    output logic [6:0] ocv_pct,
    output logic [6:0] cc_pct,
    output logic cal_active,
    output logic cal_done,
    output logic [6:0] disp_pct
);
    import fgt_pkg::*;

    typedef struct packed {
        logic [7:0] r_intv;
        logic [7:0] r_deb;
        logic [7:0] r_disp;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_got;
        logic w_got;
        logic [9:0] aw_idx;
        logic [7:0] wbyte;
        logic wlane;
        logic [16:0] ms_cnt;
        logic ms_tick;
        logic [9:0] sec_cnt;
        logic sec_tick;
        logic [9:0] corr_cnt;
        logic corr_pulse;
        logic [9:0] chg_cnt;
        logic [9:0] dis_cnt;
        logic chg_settled;
        logic dis_settled;
        fgt_deb_t ocv;
        fgt_deb_t cc;
        fgt_cal_t cal;
        logic [6:0] fin_ms;
        logic fin_seen;
        logic chg_prev;
        logic cal_done;
        logic [6:0] disp;
    } fgt_state_t;

    fgt_state_t s;
    fgt_state_t next_s;

    // One debounce step: move only after more than n same-direction steps
    function automatic fgt_deb_t fgt_deb_step(input fgt_deb_t d,
                                             input logic [6:0] raw,
                                             input logic [3:0] n);
        logic [1:0] dir;
        logic [3:0] run;
        fgt_deb_step = d;
        dir = (raw > d.pct) ? 2'h1 : 2'h2;
        run = (dir == d.dir) ? d.cnt + 4'h1 : 4'h1;
        if (raw != d.pct) begin
            fgt_deb_step.dir = dir;
            fgt_deb_step.cnt = run;
            if (run > n) begin
                fgt_deb_step.pct = raw;
                fgt_deb_step.dir = 2'h0;
                fgt_deb_step.cnt = 4'h0;
            end
        end
    endfunction

    // Decoded settings
    logic [9:0] intv_s;
    logic [9:0] chg_s;
    logic [9:0] dis_s;
    logic [6:0] start_thr;
    logic [6:0] fin_wait;
    logic start_ok;
    logic end0_ok;
    logic [7:0] status_byte;
    logic [9:0] ar_idx;

    assign intv_s = fgt_interval_s(s.r_intv[F_INTV_LSB +: 2]);
    assign chg_s = fgt_settle_s(s.r_intv[F_CHG_WAIT_LSB +: 3]);
    assign dis_s = fgt_settle_s(s.r_intv[F_DIS_WAIT_LSB +: 3]);
    assign start_thr = {3'h0, low_warning_threshold}
        + (s.r_deb[F_START_BIT] ? START_MARGIN_HI : START_MARGIN_LO);
    assign start_ok = s.ocv.pct < start_thr;
    assign end0_ok = s.r_deb[F_END0_BIT] ? (s.ocv.pct == END_PCT_HI)
                                         : (s.ocv.pct >= END_PCT_LO);
    assign fin_wait = s.r_deb[F_END2_BIT] ? FIN_WAIT_MS_HI : FIN_WAIT_MS_LO;
    assign status_byte = {2'h0, s.cal, start_ok, end0_ok,
                          s.dis_settled, s.chg_settled};
    assign ar_idx = fgt_index(s_axi_araddr);

    // Next-state logic
    always_comb begin
        next_s = s;
        next_s.ms_tick = 1'b0;
        next_s.sec_tick = 1'b0;
        next_s.corr_pulse = 1'b0;
        next_s.cal_done = 1'b0;

        // AXI write: take address and data in either order
        if (s.awready && s_axi_awvalid) begin
            next_s.awready = 1'b0;
            next_s.aw_got = 1'b1;
            next_s.aw_idx = fgt_index(s_axi_awaddr);
        end else if (!s.aw_got && !s.bvalid) begin
            next_s.awready = 1'b1;
        end
        if (s.wready && s_axi_wvalid) begin
            next_s.wready = 1'b0;
            next_s.w_got = 1'b1;
            next_s.wbyte = s_axi_wdata[7:0];
            next_s.wlane = s_axi_wstrb[0];
        end else if (!s.w_got && !s.bvalid) begin
            next_s.wready = 1'b1;
        end
        if (s.aw_got && s.w_got) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = RESP_OKAY;
            if (s.aw_idx == IDX_INTERVAL_WAIT) begin
                if (s.wlane) next_s.r_intv = s.wbyte;
            end else if (s.aw_idx == IDX_DEBOUNCE_CAL) begin
                if (s.wlane) next_s.r_deb = s.wbyte;
            end else if (s.aw_idx == IDX_DISPLAY_DEC) begin
                if (s.wlane) next_s.r_disp = s.wbyte;
            end else if (s.aw_idx != IDX_STATUS) begin
                next_s.bresp = RESP_SLVERR;
            end
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // AXI read: one word per address, answer next cycle
        if (s.arready && s_axi_arvalid) begin
            next_s.arready = 1'b0;
            next_s.rvalid = 1'b1;
            next_s.rresp = RESP_OKAY;
            next_s.rdata = 32'h0000_0000;
            if (ar_idx == IDX_INTERVAL_WAIT) begin
                next_s.rdata[7:0] = s.r_intv;
            end else if (ar_idx == IDX_DEBOUNCE_CAL) begin
                next_s.rdata[7:0] = s.r_deb;
            end else if (ar_idx == IDX_DISPLAY_DEC) begin
                next_s.rdata[7:0] = s.r_disp;
            end else if (ar_idx == IDX_STATUS) begin
                next_s.rdata[7:0] = status_byte;
            end else begin
                next_s.rresp = RESP_SLVERR;
            end
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
            next_s.arready = 1'b1;
        end else if (!s.rvalid) begin
            next_s.arready = 1'b1;
        end

        if (s.ms_cnt == 17'(MS_CYC - 1)) begin
            next_s.ms_cnt = 17'h0_0000;
            next_s.ms_tick = 1'b1;
            if (s.sec_cnt == 10'(MS_SEC - 1)) begin
                next_s.sec_cnt = 10'h000;
                next_s.sec_tick = 1'b1;
            end else begin
                next_s.sec_cnt = s.sec_cnt + 10'h001;
            end
        end else begin
            next_s.ms_cnt = s.ms_cnt + 17'h0_0001;
        end

        if (s.sec_tick) begin
            if (s.corr_cnt + 10'h001 >= intv_s) begin
                next_s.corr_cnt = 10'h000;
                next_s.corr_pulse = 1'b1;
            end else begin
                next_s.corr_cnt = s.corr_cnt + 10'h001;
            end
        end

        // charge settling, restarts when estimation re-enters
        if (!rdc_charge_est) begin
            next_s.chg_cnt = 10'h000;
            next_s.chg_settled = 1'b0;
        end else if (s.sec_tick && !s.chg_settled) begin
            next_s.chg_cnt = s.chg_cnt + 10'h001;
            next_s.chg_settled = (s.chg_cnt + 10'h001 >= chg_s);
        end
        if (!rdc_discharge_est) begin
            next_s.dis_cnt = 10'h000;
            next_s.dis_settled = 1'b0;
        end else if (s.sec_tick && !s.dis_settled) begin
            next_s.dis_cnt = s.dis_cnt + 10'h001;
            next_s.dis_settled = (s.dis_cnt + 10'h001 >= dis_s);
        end

        if (ocv_sample_valid) begin
            next_s.ocv = fgt_deb_step(s.ocv, ocv_pct_raw,
                fgt_deb_n(s.r_deb[F_OCV_DEB_LSB +: 2]));
        end
        if (cc_sample_valid) begin
            next_s.cc = fgt_deb_step(s.cc, cc_pct_raw,
                fgt_deb_n(s.r_deb[F_CC_DEB_LSB +: 2]));
        end

        // Calibration sequence
        next_s.chg_prev = charging_status_bit;
        case (s.cal)
            FGT_CAL_IDLE: begin
                if (cal_enable && start_ok) next_s.cal = FGT_CAL_RUN;
            end
            FGT_CAL_RUN: begin
                if (!cal_enable) begin
                    next_s.cal = FGT_CAL_IDLE;
                end else if (s.r_deb[F_END1_BIT] && end0_ok) begin
                    next_s.cal = FGT_CAL_DONE;
                    next_s.cal_done = 1'b1;
                end else if (s.chg_prev && !charging_status_bit) begin
                    next_s.cal = FGT_CAL_WAIT;
                    next_s.fin_ms = 7'h00;
                    next_s.fin_seen = 1'b0;
                end
            end
            FGT_CAL_WAIT: begin
                if (charge_finished) next_s.fin_seen = 1'b1;
                if (!cal_enable) begin
                    next_s.cal = FGT_CAL_IDLE;
                end else if (charging_status_bit) begin
                    next_s.cal = FGT_CAL_RUN;
                end else if (s.ms_tick) begin
                    next_s.fin_ms = s.fin_ms + 7'h01;
                    if (s.fin_ms + 7'h01 >= fin_wait) begin
                        if (end0_ok && (s.fin_seen || charge_finished
                                        || s.r_deb[F_END1_BIT])) begin
                            next_s.cal = FGT_CAL_DONE;
                            next_s.cal_done = 1'b1;
                        end else begin
                            next_s.cal = FGT_CAL_RUN;
                        end
                    end
                end
            end
            default: begin
                if (!cal_enable) next_s.cal = FGT_CAL_IDLE;
            end
        endcase

        if (disp_req_valid) begin
            if (!charging_status_bit || disp_req_pct >= s.disp) begin
                next_s.disp = disp_req_pct;
            end else if (!s.r_disp[F_HOLD_BIT] && (s.disp - disp_req_pct
                         >= fgt_hyst_pct(s.r_disp[F_HYST_LSB +: 3]))) begin
                next_s.disp = disp_req_pct;
            end
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.r_intv <= RST_INTERVAL_WAIT;
            s.r_deb <= RST_DEBOUNCE_CAL;
            s.r_disp <= RST_DISPLAY_DEC;
            s.disp <= RST_DISP_PCT;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from state
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rdata = s.rdata;
    assign correct_pulse = s.corr_pulse;
    assign chg_settled = s.chg_settled;
    assign dis_settled = s.dis_settled;
    assign ocv_pct = s.ocv.pct;
    assign cc_pct = s.cc.pct;
    assign cal_active = s.cal[0]; // Bit 0 set only in run and wait
    assign cal_done = s.cal_done;
    assign disp_pct = s.disp;

endmodule // fgt_tuning_regs
`default_nettype wire

/* tb/fgt_props.sv */
// Concurrent checks on the fuel gauge tuning block's ports.
// Assumes binding to fgt_tuning_regs and one clock domain.
`timescale 1ns/100ps
`default_nettype none
module fgt_props (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Gauge inputs
    input wire logic [3:0] low_warning_threshold,
    input wire logic cal_enable,
    input wire logic rdc_charge_est,
    input wire logic rdc_discharge_est,
    input wire logic ocv_sample_valid,
    input wire logic [6:0] ocv_pct_raw,
    input wire logic cc_sample_valid,
    input wire logic [6:0] cc_pct_raw,
    input wire logic disp_req_valid,
    input wire logic [6:0] disp_req_pct,
    // Gauge outputs
    input wire logic correct_pulse,
    input wire logic chg_settled,
    input wire logic dis_settled,
    input wire logic [6:0] ocv_pct,
    input wire logic [6:0] cc_pct,
    input wire logic cal_active,
    input wire logic cal_done,
    input wire logic [6:0] disp_pct
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_vals: assert property ($rose(aresetn) |->
        disp_pct == 7'h64 && ocv_pct == 7'h00 && cc_pct == 7'h00)
        else $error("values after reset wrong");
    a_pulse_single: assert property (correct_pulse |=>
        !correct_pulse) else $error("correction pulse too long");
    a_chg_clear: assert property (!rdc_charge_est |=>
        !chg_settled) else $error("charge settle not cleared");
    a_dis_clear: assert property (!rdc_discharge_est |=>
        !dis_settled) else $error("discharge settle not cleared");
    a_ocv_step: assert property ($changed(ocv_pct) |->
        $past(ocv_sample_valid) && ocv_pct == $past(ocv_pct_raw))
        else $error("voltage percentage moved without sample");
    a_cc_step: assert property ($changed(cc_pct) |->
        $past(cc_sample_valid) && cc_pct == $past(cc_pct_raw))
        else $error("count percentage moved without sample");
    a_cal_start: assert property ($rose(cal_active) |->
        $past(cal_enable) && $past(ocv_pct) <
        {3'h0, $past(low_warning_threshold)} + 7'h06)
        else $error("calibration started above threshold");
    a_done_end: assert property (cal_done |->
        $past(ocv_pct) >= 7'h5F && !cal_active ##1 !cal_done)
        else $error("calibration ended too early");
    a_disp_src: assert property ($changed(disp_pct) |->
        $past(disp_req_valid) && disp_pct == $past(disp_req_pct))
        else $error("display moved without request");
    // Main scenarios reached
    c_done: cover property (cal_done);
    c_pulse: cover property (correct_pulse);
    c_settle: cover property ($rose(chg_settled));
    c_disp: cover property ($changed(disp_pct));
endmodule // fgt_props
`default_nettype wire

/* tb/fgt_tuning_regs_bench.sv */
// Self-checking bench for the fuel gauge tuning registers.
// Assumes fgt_pkg, fgt_tuning_regs and fgt_props compiled first.
`timescale 1ns/100ps
`default_nettype none
module fgt_tuning_regs_bench;
    import fgt_pkg::*;
    localparam int SEC = 12; // Cycles per second, MS_CYC 4 and MS_SEC 3
    localparam logic [11:0] A_IW = {IDX_INTERVAL_WAIT, 2'h0};
    localparam logic [11:0] A_DC = {IDX_DEBOUNCE_CAL, 2'h0};
    localparam logic [11:0] A_DD = {IDX_DISPLAY_DEC, 2'h0};
    logic aclk, aresetn;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, low_warning_threshold, s;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, charging_status_bit, charge_finished, cal_enable;
    logic rdc_charge_est, rdc_discharge_est, ocv_sample_valid;
    logic cc_sample_valid, disp_req_valid;
    logic [6:0] ocv_pct_raw, cc_pct_raw, disp_req_pct, v, e;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, correct_pulse, chg_settled, dis_settled;
    logic cal_active, cal_done;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [6:0] ocv_pct, cc_pct, disp_pct;
    logic [7:0] m[3];
    logic [11:0] ad[3];
    int fails, n_tests, n_done, w, tc, td, c, k;
    logic [33:0] exp_q[$];
    int sett[8] = '{180, 240, 300, 600, 30, 60, 90, 120};
    int intv[4] = '{60, 120, 15, 30};
    int debn[4] = '{4, 8, 1, 2};
    int ord[4] = '{1, 0, 2, 3};

    fgt_tuning_regs #(.MS_CYC(4), .MS_SEC(3)) DUT (.*);

    // Clock at 125 MHz
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("Compares %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // One bounded clock step of a wait
    task automatic tick(inout int n, input int lim);
        @(posedge aclk);
        n++;
        if (n > lim) begin
            $display("Wait limit hit at %0t", $time);
            fails++;
            final_report();
        end
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] dt,
                          input logic [3:0] st, input logic [1:0] r);
        int n;
        n = 0;
        exp_q.push_back({r, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= dt;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            tick(n, 50);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] dt);
        axi_wr(a, {24'h0, dt}, 4'hF, RESP_OKAY);
    endtask

    task automatic axi_rd(input logic [11:0] a, input logic [33:0] ex);
        int n;
        n = 0;
        exp_q.push_back(ex);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            tick(n, 50);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
    endtask

    // One voltage and count sample, then settle
    task automatic smp(input logic [6:0] x);
        {ocv_sample_valid, cc_sample_valid} <= 2'h3;
        {ocv_pct_raw, cc_pct_raw} <= {x, x};
        @(posedge aclk);
        {ocv_sample_valid, cc_sample_valid} <= 2'h0;
        repeat (3) @(posedge aclk);
    endtask

    task automatic dsp(input logic [6:0] x, input logic [6:0] ex);
        disp_req_valid <= 1'b1;
        disp_req_pct <= x;
        @(posedge aclk);
        disp_req_valid <= 1'b0;
        repeat (2) @(posedge aclk);
        chk(34'(disp_pct), 34'(ex));
    endtask

    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask

    function automatic bit in_win(input int t, input int lo, input int hi);
        return t >= lo && t <= hi;
    endfunction

    // Bus answers against the oldest note
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready)
            chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        if (s_axi_bvalid && s_axi_bready)
            chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
    end

    // Calibration end pulses seen
    always @(posedge aclk) begin
        if (cal_done === 1'b1) n_done++;
    end

    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, cal_enable} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {charging_status_bit, charge_finished} = 2'h0;
        {rdc_charge_est, rdc_discharge_est} = 2'h0;
        {ocv_sample_valid, cc_sample_valid, disp_req_valid} = 3'h0;
        {ocv_pct_raw, cc_pct_raw, disp_req_pct} = '0;
        low_warning_threshold = 4'h0;
        ad = '{A_IW, A_DC, A_DD};
        m = '{8'h00, 8'h00, 8'h00};
        void'($urandom(58779));
        do_reset();
        for (int i = 0; i < 3; i++) axi_rd(ad[i], 34'h0);
        axi_rd(12'h004, {RESP_SLVERR, 32'h0});
        axi_wr(12'h004, 32'h5A, 4'hF, RESP_SLVERR);
        for (int i = 0; i < 12; i++) begin
            k = $urandom_range(2);
            d = $urandom;
            s = 4'($urandom);
            axi_wr(ad[k], d, s, RESP_OKAY);
            if (s[0]) m[k] = d[7:0];
            axi_rd(ad[k], {RESP_OKAY, 24'h0, m[k]});
        end
        do_reset();
        axi_rd(A_DD, 34'h0);
        axi_rd({IDX_STATUS, 2'h0}, {RESP_OKAY, 32'h0000_0008});
        $display("Register test done");
        for (int i = 0; i < 4; i++) begin
            wr(A_IW, 8'(i << 6));
            for (int j = 0; j < 2; j++) begin
                w = 0;
                do tick(w, 2000); while (!correct_pulse);
            end
            chk(34'(w), 34'(intv[i] * SEC));
        end
        $display("Interval test done");
        for (int i = 0; i < 8; i++) begin
            wr(A_IW, {2'h0, 3'(i), 3'(7 - i)});
            rdc_charge_est <= 1'b1;
            rdc_discharge_est <= 1'b1;
            {w, tc, td} = '0;
            do begin
                tick(w, 7500);
                if (chg_settled && tc == 0) tc = w;
                if (dis_settled && td == 0) td = w;
            end while (tc == 0 || td == 0);
            c = sett[i] * SEC;
            chk(34'(in_win(tc, c - SEC, c + 3)), 34'h1);
            c = sett[7 - i] * SEC;
            chk(34'(in_win(td, c - SEC, c + 3)), 34'h1);
            rdc_charge_est <= 1'b0;
            rdc_discharge_est <= 1'b0;
            repeat (2) @(posedge aclk);
            chk(34'({chg_settled, dis_settled}), 34'h0);
        end
        $display("Settling test done");
        v = 7'h00;
        for (int i = 0; i < 4; i++) begin
            c = ord[i];
            wr(A_DC, {2'(c), 2'(c), 4'h0});
            for (k = 1; k <= debn[c] + 1; k++) begin
                e = (i % 2 == 0) ? v + 7'(k) : v - 7'(k);
                smp(e);
                if (k <= debn[c]) e = v;
                chk({20'h0, ocv_pct, cc_pct}, {20'h0, e, e});
            end
            v = e;
        end
        $display("Debounce test done");
        cal_enable <= 1'b1;
        wr(A_DC, 8'hA2);
        repeat (4) @(posedge aclk);
        chk(34'(cal_active), 34'h0);
        wr(A_DC, 8'hAE);
        repeat (2) @(posedge aclk);
        chk(34'(cal_active), 34'h1);
        smp(7'h5E);
        smp(7'h5F);
        chk({cal_active, 33'(n_done)}, {1'b1, 33'h0});
        smp(7'h63);
        smp(7'h64);
        chk({cal_active, 33'(n_done)}, 34'h1);
        low_warning_threshold <= 4'h5;
        for (int b = 0; b < 2; b++) begin
            cal_enable <= 1'b0;
            wr(A_DC, {7'h50, 1'(b)});
            smp(7'h32);
            smp(7'h07);
            cal_enable <= 1'b1;
            charging_status_bit <= 1'b1;
            charge_finished <= 1'b0;
            smp(7'h5F);
            smp(7'h60);
            charging_status_bit <= 1'b0;
            repeat (500) @(posedge aclk);
            chk({cal_active, 33'(n_done)}, {1'b1, 33'(b + 1)});
            charging_status_bit <= 1'b1;
            charge_finished <= 1'b1;
            repeat (2) @(posedge aclk);
            charging_status_bit <= 1'b0;
            w = 0;
            do tick(w, 600); while (!cal_done);
            c = b ? 480 : 272;
            chk(34'(in_win(w, c - 4, c + 4)), 34'h1);
        end
        $display("Calibration test done");
        charging_status_bit <= 1'b1;
        v = 7'h64;
        for (int h = 0; h < 4; h++) begin
            wr(A_DD, {1'b0, 3'(h), 4'h0});
            dsp(v - 7'(h + 3), v);
            v = v - 7'(h + 4);
            dsp(v, v);
        end
        wr(A_DD, 8'h80);
        dsp(7'h32, v);
        charging_status_bit <= 1'b0;
        dsp(7'h32, 7'h32);
        $display("Display test done");
        final_report();
    end
endmodule // fgt_tuning_regs_bench
bind fgt_tuning_regs fgt_props u_props (.*);
`default_nettype wire
